// >>> design/sasf_frame.sv
// Purpose: serial command decode and result framing of a 12-bit converter
// Assumes: converter core hands results back through resultData/resultValid
// Notes: serial clock is sampled by clk; the serial output changes only on its falling edges and when select high clears it
`timescale 1ns/10ps
`default_nettype none
`include "sasf_map.svh"
module sasf_frame
    import sasf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic selectAndStandbyN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic eightInput,
    output logic serialOut,
    output logic serialOutEn,
    output logic standby,
    output logic sampleHold,
    output logic sampleStart,
    output logic [2:0] positiveInput,
    output logic [2:0] negativeInput,
    output logic pseudoDiff,
    input wire logic [11:0] resultData,
    input wire logic resultValid,
    output logic resultReady,
    output logic frameBusy
);
    sasf_link_if link();
    sasf_state_type state_reg, state_next;
    sasf_cmd_type cmd_reg, cmd_next;
    logic armed_reg, armed_next;
    logic [3:0] bitIdx_reg, bitIdx_next;
    logic [11:0] word_reg, word_next;
    logic out_reg, out_next;
    logic oen_reg, oen_next;
    logic hold_reg, hold_next;
    logic start_reg, start_next;
    logic [2:0] pos_reg, pos_next, neg_reg, neg_next;
    logic diff_reg, diff_next;
    logic fifoValid, fifoReady;
    logic [11:0] fifoData;

    sasf_pin_sync sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .selPinN(selectAndStandbyN),
        .sclkPin(serialClk),
        .dataPin(serialIn),
        .link(link)
    );

    // results queue here so a slow drain holds the core off via resultReady
    sasf_fifo #(.WIDTH(`SASF_RES_BITS), .DEPTH(`SASF_FIFO_DEPTH)) resq (
        .clk(clk),
        .sys_rst(sys_rst),
        .inData(resultData),
        .inValid(resultValid),
        .inReady(resultReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoReady)
    );

    // the null-bit edge pops one result; a core that never answers yields zero
    assign fifoReady = (state_reg == SASF_SAMPLE) && (bitIdx_reg == 4'h1) && link.sclkFall
        && !link.selHigh;

    // framing state machine
    always_comb
    begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        armed_next = armed_reg;
        bitIdx_next = bitIdx_reg;
        word_next = word_reg;
        out_next = out_reg;
        oen_next = oen_reg;
        hold_next = hold_reg;
        start_next = 1'b0;
        pos_next = pos_reg;
        neg_next = neg_reg;
        diff_next = diff_reg;
        if (link.selHigh)
        begin
            // select high aborts everything and releases the output
            state_next = SASF_IDLE;
            armed_next = armed_reg | link.selRise; // armed by a seen rise
            oen_next = 1'b0;
            out_next = 1'b0;
            hold_next = 1'b0;
        end
        else if (!armed_reg)
        begin
            // low since reset: stay put until select has been seen high
            state_next = SASF_WAIT_HIGH;
        end
        else
        begin
            unique case (state_reg)
                SASF_WAIT_HIGH:
                begin
                    // only reached once armed; falls through to idle
                    state_next = SASF_IDLE;
                end
                SASF_IDLE:
                begin
                    // leading zeros never look like a start bit
                    if (link.sclkRise && link.dataIn)
                    begin
                        state_next = SASF_MODE;
                    end
                end
                SASF_MODE:
                begin
                    if (link.sclkRise)
                    begin
                        cmd_next.singleEnded = link.dataIn;
                        state_next = SASF_CH2;
                    end
                end
                SASF_CH2:
                begin
                    if (link.sclkRise)
                    begin
                        cmd_next.chanSel[2] = link.dataIn;
                        state_next = SASF_CH1;
                    end
                end
                SASF_CH1:
                begin
                    if (link.sclkRise)
                    begin
                        cmd_next.chanSel[1] = link.dataIn;
                        state_next = SASF_CH0;
                    end
                end
                SASF_CH0:
                begin
                    if (link.sclkRise)
                    begin
                        cmd_next.chanSel[0] = link.dataIn;
                        // the window opens on the edge that takes the last channel bit
                        bitIdx_next = 4'h0;
                        hold_next = 1'b1;
                        start_next = 1'b1;
                        state_next = SASF_SAMPLE;
                    end
                end
                SASF_SAMPLE:
                begin
                    // the fall of the channel bit 0 clock would cut the window to half
                    // a clock, so wait for the sample clock's rise and end on its fall
                    // serial input is no longer looked at from here on
                    if (link.sclkRise)
                    begin
                        bitIdx_next = 4'h1;
                    end
                    if (link.sclkFall && (bitIdx_reg == 4'h1))
                    begin
                        hold_next = 1'b0;
                        oen_next = 1'b1;
                        out_next = 1'b0;
                        word_next = fifoValid ? fifoData : `SASF_CODE_MIN;
                        bitIdx_next = 4'h0;
                        state_next = SASF_NULL;
                    end
                end
                SASF_NULL:
                begin
                    // first msb-first bit follows the null bit
                    if (link.sclkFall)
                    begin
                        out_next = word_reg[11];
                        bitIdx_next = 4'h1;
                        state_next = SASF_MSB;
                    end
                end
                SASF_MSB:
                begin
                    if (link.sclkFall)
                    begin
                        if (bitIdx_reg == `SASF_LSB_LAST + 4'h1)
                        begin
                            // lsb already out; shared, so next goes bit 1
                            out_next = word_reg[1];
                            bitIdx_next = 4'h2;
                            state_next = SASF_LSB;
                        end
                        else
                        begin
                            out_next = word_reg[4'd11 - bitIdx_reg];
                            bitIdx_next = bitIdx_reg + 4'h1;
                        end
                    end
                end
                SASF_LSB:
                begin
                    // lsb-first copy reuses bit 0 already sent
                    if (link.sclkFall)
                    begin
                        if (bitIdx_reg == `SASF_LSB_LAST + 4'h1)
                        begin
                            out_next = 1'b0;
                            state_next = SASF_ZERO;
                        end
                        else
                        begin
                            out_next = word_reg[bitIdx_reg];
                            bitIdx_next = bitIdx_reg + 4'h1;
                        end
                    end
                end
                SASF_ZERO:
                begin
                    // zeros until select goes high; the output stays driven
                    out_next = 1'b0;
                end
            endcase
        end
        // mux steering follows the decoded command
        // the four-input part drops the top channel bit in both modes
        if (cmd_next.singleEnded)
        begin
            diff_next = 1'b0;
            pos_next = {cmd_next.chanSel[2] & eightInput, cmd_next.chanSel[1:0]};
            neg_next = 3'h0;
        end
        else
        begin
            diff_next = 1'b1;
            pos_next = {cmd_next.chanSel[2] & eightInput, cmd_next.chanSel[1],
                cmd_next.chanSel[0]};
            neg_next = {cmd_next.chanSel[2] & eightInput, cmd_next.chanSel[1],
                ~cmd_next.chanSel[0]};
        end
    end

    // state registers; reset leaves select unseen so a low-held select waits
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= SASF_WAIT_HIGH;
            cmd_reg <= '0;
            armed_reg <= 1'b0;
            bitIdx_reg <= 4'h0;
            word_reg <= 12'h000;
            out_reg <= 1'b0;
            oen_reg <= 1'b0;
            hold_reg <= 1'b0;
            start_reg <= 1'b0;
            pos_reg <= 3'h0;
            neg_reg <= 3'h0;
            diff_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            armed_reg <= armed_next;
            bitIdx_reg <= bitIdx_next;
            word_reg <= word_next;
            out_reg <= out_next;
            oen_reg <= oen_next;
            hold_reg <= hold_next;
            start_reg <= start_next;
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            diff_reg <= diff_next;
        end
    end

    // standby and busy are registered copies of the state
    // taken from the next state so they line up with the output enable
    logic stby_reg, busy_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stby_reg <= 1'b1;
            busy_reg <= 1'b0;
        end
        else
        begin
            stby_reg <= (state_next == SASF_IDLE) || (state_next == SASF_WAIT_HIGH);
            busy_reg <= (state_next != SASF_IDLE) && (state_next != SASF_WAIT_HIGH);
        end
    end

    assign serialOut = out_reg;
    assign serialOutEn = oen_reg;
    assign standby = stby_reg;
    assign sampleHold = hold_reg;
    assign sampleStart = start_reg;
    assign positiveInput = pos_reg;
    assign negativeInput = neg_reg;
    assign pseudoDiff = diff_reg;
    assign frameBusy = busy_reg;
endmodule
`default_nettype wire

// >>> design/sasf_map.svh
// Purpose: constants for the serial command and result framing of the converter
// Assumes: 250 MHz system clock samples the serial pins
// Notes: all counts are in serial clock edges unless named otherwise
//
// Contract
// - a transaction starts only with select low; select high ignores clock and data
// - if select low at power-up, wait for select high then low first
// - first rising edge with select low and data high is the start bit
// - leading low bits before the start bit are ignored
// - bit after start picks mode: 1 single-ended, 0 pseudo-differential
// - next three bits pick channel 0..7 in single-ended mode
// - differential: bits 2,1 pick pair, bit 0 swaps positive and negative
// - four-input variant ignores channel bit 2
// - sampling starts on the edge capturing channel bit 0
// - sampling lasts 1.5 clocks, ends on falling edge of fifth clock
// - one more clock finishes sampling; data input ignored from then on
// - low null bit driven on falling edge after the sampling clock
// - next 12 clocks shift the result out msb first
// - serial output changes only on falling serial clock edges
// - further clocks repeat the result lsb first, sharing the lsb
// - after the lsb-first copy, zeros are driven while select stays low
// - select high ends any conversion, returns to idle, enters standby
// - code is 4096*vin/vref clamped; differential at or below negative gives 000h
// - serial output stays high impedance before the null bit
`ifndef SASF_MAP_SVH
`define SASF_MAP_SVH
`define SASF_RES_BITS 12
`define SASF_CODE_MAX 12'hfff
`define SASF_CODE_MIN 12'h000
`define SASF_LSB_LAST 4'hb
`define SASF_FIFO_DEPTH 4
`define SASF_HOLD_TIME_US 1200
`define SASF_HOLD_CYCLES (`SASF_HOLD_TIME_US * 250)
`endif

// >>> design/sasf_pkg.sv
// Purpose: types for the serial framing block
// Assumes: nothing
// Notes: constants live in sasf_map.svh
`default_nettype none
package sasf_pkg;
    typedef enum logic [3:0] {
        SASF_WAIT_HIGH, SASF_IDLE, SASF_MODE, SASF_CH2, SASF_CH1, SASF_CH0,
        SASF_SAMPLE, SASF_NULL, SASF_MSB, SASF_LSB, SASF_ZERO
    } sasf_state_type;
    typedef struct packed {
        logic singleEnded;
        logic [2:0] chanSel;
    } sasf_cmd_type;
endpackage
`default_nettype wire

// >>> design/sasf_link_if.sv
// Purpose: carries sampled serial pin events between the edge finder and the framer
// Assumes: one system clock
// Notes: pulses last one system cycle
`timescale 1ns/10ps
`default_nettype none
interface sasf_link_if;
    logic selHigh;
    logic selRise;
    logic sclkRise;
    logic sclkFall;
    logic dataIn;
    modport src (output selHigh, output selRise, output sclkRise, output sclkFall,
        output dataIn);
    modport dst (input selHigh, input selRise, input sclkRise, input sclkFall,
        input dataIn);
endinterface
`default_nettype wire

// >>> design/sasf_pin_sync.sv
// Purpose: three-stage pin synchroniser with edge pulses
// Assumes: pins are asynchronous to clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module sasf_pin_sync
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic selPinN,
    input wire logic sclkPin,
    input wire logic dataPin,
    sasf_link_if.src link
);
    logic [2:0] selSh_reg, selSh_next;
    logic [2:0] clkSh_reg, clkSh_next;
    logic [2:0] datSh_reg, datSh_next;
    logic selSt_reg, selSt_next;
    logic clkSt_reg, clkSt_next;
    logic datSt_reg, datSt_next;
    logic selRise_reg, selRise_next;
    logic rise_reg, rise_next;
    logic fall_reg, fall_next;

    // settled level only moves when the later two stages agree
    always_comb
    begin
        selSh_next = {selSh_reg[1:0], selPinN};
        clkSh_next = {clkSh_reg[1:0], sclkPin};
        datSh_next = {datSh_reg[1:0], dataPin};
        selSt_next = (selSh_reg[1] == selSh_reg[2]) ? selSh_reg[2] : selSt_reg;
        clkSt_next = (clkSh_reg[1] == clkSh_reg[2]) ? clkSh_reg[2] : clkSt_reg;
        datSt_next = (datSh_reg[1] == datSh_reg[2]) ? datSh_reg[2] : datSt_reg;
        selRise_next = selSt_next & ~selSt_reg;
        rise_next = clkSt_next & ~clkSt_reg;
        fall_next = ~clkSt_next & clkSt_reg;
    end

    // select resets unseen (low) so a select held low since power-up cannot start a frame
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            selSh_reg <= 3'h0;
            clkSh_reg <= 3'h0;
            datSh_reg <= 3'h0;
            selSt_reg <= 1'h0;
            clkSt_reg <= 1'h0;
            datSt_reg <= 1'h0;
            selRise_reg <= 1'h0;
            rise_reg <= 1'h0;
            fall_reg <= 1'h0;
        end
        else
        begin
            selSh_reg <= selSh_next;
            clkSh_reg <= clkSh_next;
            datSh_reg <= datSh_next;
            selSt_reg <= selSt_next;
            clkSt_reg <= clkSt_next;
            datSt_reg <= datSt_next;
            selRise_reg <= selRise_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign link.selHigh = selSt_reg;
    assign link.selRise = selRise_reg;
    assign link.sclkRise = rise_reg;
    assign link.sclkFall = fall_reg;
    assign link.dataIn = datSt_reg;
endmodule
`default_nettype wire

// >>> design/sasf_fifo.sv
// Purpose: small result FIFO between the converter core and the framer
// Assumes: single clock
// Notes: full and empty are exact; no write when full
`timescale 1ns/10ps
`default_nettype none
module sasf_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic doWr, doRd;
    logic rdy_reg, rdy_next;

    // pointers and fill count
    always_comb
    begin
        doWr = inValid && inReady;
        doRd = outValid && outReady;
        wp_next = doWr ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next = doRd ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = AW'(0) + cnt_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
        rdy_next = (cnt_next != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b1;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
        end
    end

    // storage has no reset; contents are only read when counted valid
    always_ff @(posedge clk)
    begin
        if (doWr)
        begin
            mem[wp_reg] <= inData;
        end
    end

    // ready is registered so it leaves the block straight from a flop
    assign inReady = rdy_reg;
    assign outValid = (cnt_reg != '0);
    assign outData = mem[rp_reg];
endmodule
`default_nettype wire

// >>> test/sasf_frame_assertions.sv
// Purpose: concurrent checks on the framer top ports
// Assumes: serial period near 125 ns against a 4 ns clk
// Notes: windows leave room for the pin synchroniser delay
`timescale 1ns/10ps
`default_nettype none
module sasf_frame_assertions
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic selectAndStandbyN,
    input wire logic serialClk,
    input wire logic eightInput,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic standby,
    input wire logic sampleHold,
    input wire logic sampleStart,
    input wire logic [2:0] positiveInput,
    input wire logic [2:0] negativeInput,
    input wire logic pseudoDiff,
    input wire logic frameBusy
);
    logic [7:0] holdLen;
    logic [7:0] sinceFall;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // window length and age of the last serial fall; the age saturates so a stuck pin cannot wrap it
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            holdLen <= 8'h00;
            sinceFall <= 8'hff;
        end
        else
        begin
            holdLen <= sampleHold ? holdLen + 8'h01 : 8'h00;
            sinceFall <= $fell(serialClk) ? 8'h00 : sinceFall + {7'h00, sinceFall != 8'hff};
        end
    end
    sequence s_null;
        serialOutEn && !serialOut;
    endsequence
    sequence s_idle;
        standby && !frameBusy && !serialOutEn;
    endsequence
    property p_sel_high;
        selectAndStandbyN [*8] |-> s_idle;
    endproperty
    a_sel_high: assert property (p_sel_high) else $error("busy while deselected");
    property p_abort;
        $rose(selectAndStandbyN) |-> ##[1:8] s_idle;
    endproperty
    a_abort: assert property (p_abort) else $error("no standby after deselect");
    property p_busy_start;
        $rose(frameBusy) |-> !standby && !selectAndStandbyN;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("frame began badly");
    property p_start_hold;
        sampleStart |-> ##[0:1] sampleHold;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("no window at start");
    property p_hold_len;
        $fell(sampleHold) |-> holdLen inside {[44:50]};
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("window length wrong");
    property p_null;
        $fell(sampleHold) |-> ##[0:2] s_null;
    endproperty
    a_null: assert property (p_null) else $error("no null bit after window");
    property p_quiet;
        sampleHold |-> !serialOutEn;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output driven too early");
    property p_fall_only;
        serialOutEn && $changed(serialOut) |-> sinceFall <= 8'h0a;
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("output moved off a fall");
    property p_stands;
        serialOutEn && !selectAndStandbyN |=> serialOutEn;
    endproperty
    a_stands: assert property (p_stands) else $error("output released early");
    property p_diff;
        sampleHold && pseudoDiff |-> negativeInput == (positiveInput ^ 3'h1);
    endproperty
    a_diff: assert property (p_diff) else $error("pair not adjacent");
    property p_four;
        sampleHold && !eightInput |-> !positiveInput[2] && !negativeInput[2];
    endproperty
    a_four: assert property (p_four) else $error("bit two used on four inputs");
endmodule
bind sasf_frame sasf_frame_assertions chk
(
    .clk(clk), .sys_rst(sys_rst), .selectAndStandbyN(selectAndStandbyN),
    .serialClk(serialClk), .eightInput(eightInput), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .standby(standby), .sampleHold(sampleHold),
    .sampleStart(sampleStart), .positiveInput(positiveInput),
    .negativeInput(negativeInput), .pseudoDiff(pseudoDiff), .frameBusy(frameBusy)
);
`default_nettype wire

// >>> test/sasf_host_model.sv
// Purpose: serial host that frames commands and collects the answer bits
// Assumes: 125 ns serial period, either clock idle level
// Notes: a released output is recorded as z so early driving shows up
`timescale 1ns/10ps
`default_nettype none
module sasf_host_model
(
    output var logic selN,
    output var logic sclk,
    output var logic din,
    input wire logic serialOut,
    input wire logic serialOutEn,
    output var logic [47:0] rxBits,
    output var logic rxDone
);
    localparam realtime HalfNs = 62.5;
    // select starts low to exercise the power-up case
    initial
    begin
        selN = 1'b0;
        sclk = 1'b0;
        din = 1'b0;
        rxBits = 48'h0;
        rxDone = 1'b0;
    end
    // one select-low period; clock stands still outside it
    task automatic frame(input logic [3:0] cmd, input int lead, input int nClk,
        input bit idleHigh, input bit skipHigh);
        int i;
        logic [31:0] junk;
        if (!skipHigh)
        begin
            selN = 1'b1;
            sclk = idleHigh;
            #(HalfNs * 4);
        end
        selN = 1'b0;
        rxBits = 48'h0;
        for (i = 0; i < lead + 5 + nClk; i++)
        begin
            sclk = 1'b0;
            junk = $urandom;
            // zeros, start, mode, three channel bits, then garbage
            din = (i < lead) ? 1'b0 : (i == lead) ? 1'b1 :
                (i <= lead + 4) ? cmd[lead + 4 - i] : junk[0];
            #HalfNs;
            sclk = 1'b1;
            if (i > lead)
                rxBits = {rxBits[46:0], serialOutEn ? serialOut : 1'bz};
            #HalfNs;
        end
        if (!idleHigh)
            sclk = 1'b0;
        #HalfNs;
        selN = 1'b1;
        rxDone = 1'b1;
        #HalfNs;
        rxDone = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench for the serial framer
// Assumes: host model drives the pins, bench drives the result FIFO
// Notes: expectations are queued by the driver and popped by watchers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, sys_rst, eightInput, resultValid;
    logic [11:0] resultData;
    logic selN, sclk, din, serialOut, serialOutEn, standby, sampleHold, sampleStart;
    logic [2:0] positiveInput, negativeInput;
    logic pseudoDiff, resultReady, frameBusy, rxDone;
    logic [47:0] rxBits;
    logic [6:0] expMux;
    int err_total;
    int tests_run;
    int i;
    logic [47:0] bitQ[$];
    logic [6:0] muxQ[$];
    logic [11:0] wordQ[$];
    sasf_frame dut
    (
        .clk(clk), .sys_rst(sys_rst), .selectAndStandbyN(selN), .serialClk(sclk),
        .serialIn(din), .eightInput(eightInput), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .standby(standby), .sampleHold(sampleHold),
        .sampleStart(sampleStart), .positiveInput(positiveInput),
        .negativeInput(negativeInput), .pseudoDiff(pseudoDiff), .resultData(resultData),
        .resultValid(resultValid), .resultReady(resultReady), .frameBusy(frameBusy)
    );
    sasf_host_model host
    (
        .selN(selN), .sclk(sclk), .din(din), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .rxBits(rxBits), .rxDone(rxDone)
    );
    // 250 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp_bits(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: bits %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_mux(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: mux %h expected %h", $time, got, exp);
        end
    endtask
    // n rises after the start bit: five quiet, null, msb first, lsb first, zeros
    function automatic logic [47:0] exp_bits(input logic [11:0] w, input int n, input bit dead);
        logic [47:0] v;
        logic b;
        int k;
        v = 48'h0;
        for (k = 0; k < n; k++)
        begin
            b = (dead || k < 5) ? 1'bz : (k == 5) ? 1'b0 :
                (k < 18) ? w[17 - k] : (k < 29) ? w[k - 17] : 1'b0;
            v = {v[46:0], b};
        end
        return v;
    endfunction
    // hold valid until an edge that sees ready high
    task automatic push_word(input logic [11:0] w);
        @(posedge clk);
        resultData <= w;
        resultValid <= 1'b1;
        @(negedge clk);
        while (resultReady !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        resultValid <= 1'b0;
        wordQ.push_back(w);
    endtask
    task automatic run_frame(input logic [3:0] cmd, input bit skip);
        int lead;
        int nClk;
        logic [11:0] w;
        logic [2:0] pos;
        lead = $urandom_range(7, 0);
        nClk = $urandom_range(40, 2);
        w = 12'h000;
        if (!skip && wordQ.size() > 0)
            w = wordQ.pop_front();
        pos = {cmd[2] & eightInput, cmd[1:0]};
        if (!skip)
            muxQ.push_back({~cmd[3], pos, cmd[3] ? 3'h0 : pos ^ 3'h1});
        bitQ.push_back(exp_bits(w, 4 + nClk, skip));
        host.frame(cmd, lead, nClk, cmd[0], skip);
    endtask
    // watchers take the oldest note whenever a result shows
    always @(posedge rxDone)
        cmp_bits(rxBits, bitQ.size() > 0 ? bitQ.pop_front() : 48'hx);
    always @(negedge sampleHold iff !sys_rst)
    begin
        expMux = (muxQ.size() > 0) ? muxQ.pop_front() : 7'hx;
        cmp_mux({pseudoDiff, positiveInput, negativeInput}, expMux);
    end
    // main sequence
    initial
    begin
        err_total = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        eightInput = 1'b1;
        resultValid = 1'b0;
        resultData = 12'h000;
        void'($urandom(40));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        run_frame(4'hf, 1'b1);
        for (i = 0; i < 4; i++)
            push_word(12'($urandom));
        @(posedge clk);
        resultValid <= 1'b1;
        repeat (3) @(negedge clk);
        cmp_mux({6'h00, resultReady}, 7'h00);
        @(posedge clk);
        resultValid <= 1'b0;
        // every command code on both variants; fifo drained then refilled one by one
        for (i = 0; i < 32; i++)
        begin
            @(posedge clk);
            eightInput <= i[4];
            @(negedge clk);
            if (i > 4)
                push_word((i == 5) ? 12'hfff : 12'($urandom));
            run_frame(i[3:0], 1'b0);
        end
        repeat (20) @(posedge clk);
        give_verdict();
    end
    // watchdog well past the longest expected run
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
